//--- rtl/mci_motion_cmd.sv
// Motion command interpreter: parses nine-byte frames, updates target
// velocity or target position and returns a status reply.
// Assumes rx_byte/rx_valid come from logic on clk; stored points are
// written through the point write port by other command logic.
`timescale 1ns/1ps
module mci_motion_cmd
#(
	parameter int POINTS = mci_pkg::POINT_COUNT
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] module_addr,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	input wire logic signed [31:0] actual_position,
	input wire logic point_we,
	input wire logic [4:0] point_idx,
	input wire logic signed [31:0] point_data,
	output logic reply_valid,
	output logic [7:0] reply_status,
	output logic [7:0] reply_instr,
	output logic velocity_mode,
	output logic signed [31:0] target_velocity,
	output logic signed [31:0] target_position,
	output logic target_velocity_we,
	output logic target_position_we,
	output logic move_negative
);
	// Index field and write port are five bits wide: at most 32 points
	if (POINTS < 1 || POINTS > 32)
	begin : g_bad_points
		$error("POINTS must be 1 to 32");
	end

	logic [7:0] frame [0:8];
	logic [3:0] byte_cnt;
	logic [7:0] sum;
	logic signed [31:0] points [0:POINTS-1];

	// Byte collection: value bytes arrive most significant first
	wire frame_done = rx_valid && (byte_cnt == 4'(mci_pkg::FRAME_BYTES - 1));
	wire [7:0] f_instr = frame[1];
	wire [7:0] f_type = frame[2];
	wire [7:0] f_motor = frame[3];
	wire signed [31:0] f_value = {frame[4], frame[5], frame[6], frame[7]};
	wire sum_ok = (sum == rx_byte);
	wire addr_ok = (frame[0] == module_addr);
	// Stored point index only checked for the point variant
	wire point_ok = (f_value >= 0) && (f_value <= mci_pkg::POINT_MAX)
		&& (f_value < POINTS);
	wire motor_ok = (f_motor == mci_pkg::MOTOR_ONLY);
	wire is_rot = (f_instr == mci_pkg::INSTR_ROT_POS)
		|| (f_instr == mci_pkg::INSTR_ROT_NEG);
	wire is_stop = (f_instr == mci_pkg::INSTR_STOP);
	wire is_move = (f_instr == mci_pkg::INSTR_MOVE);
	wire is_pt = is_move && (f_type == mci_pkg::TYPE_POINT);
	wire type_ok = !is_move || (f_type == mci_pkg::TYPE_ABS)
		|| (f_type == mci_pkg::TYPE_REL) || is_pt;
	// Wraparound add keeps 32 bits; host keeps the result in range
	wire signed [31:0] rel_target = actual_position + f_value;
	wire signed [31:0] pt_target = points[f_value[4:0]];
	wire signed [31:0] new_target = (f_type == mci_pkg::TYPE_ABS) ? f_value :
		(f_type == mci_pkg::TYPE_REL) ? rel_target : pt_target;
	// Modular difference chooses the shorter way round
	wire signed [31:0] travel = new_target - actual_position;
	wire known = is_rot || is_stop || is_move;
	wire unit_ok = is_pt || motor_ok;
	wire [7:0] next_status = !sum_ok ? mci_pkg::STATUS_BAD_CHECKSUM :
		!known ? mci_pkg::STATUS_BAD_CMD :
		!type_ok ? mci_pkg::STATUS_BAD_TYPE :
		(!unit_ok || (is_pt && !point_ok)) ? mci_pkg::STATUS_BAD_VALUE :
		mci_pkg::STATUS_OK;
	wire exec = frame_done && addr_ok && (next_status == mci_pkg::STATUS_OK);

	// Frame counter and running checksum; frame ends on ninth byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			byte_cnt <= 4'h0;
			sum <= 8'h00;
		end
		else if (ce && rx_valid)
		begin
			frame[byte_cnt] <= rx_byte;
			byte_cnt <= frame_done ? 4'h0 : byte_cnt + 4'h1;
			sum <= frame_done ? 8'h00 : sum + rx_byte;
		end
	end

	// Stored point table, written by the point-setting commands
	always_ff @(posedge clk)
	begin
		if (ce && point_we && (32'(point_idx) < POINTS))
			points[point_idx] <= point_data;
	end

	// Reply goes out the cycle after the last byte; frames for other
	// addresses get no reply so the bus stays free for that node
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reply_valid <= 1'b0;
			reply_status <= 8'h00;
			reply_instr <= 8'h00;
		end
		else if (ce)
		begin
			reply_valid <= frame_done && addr_ok;
			if (frame_done && addr_ok)
			begin
				reply_status <= next_status;
				reply_instr <= f_instr;
			end
		end
	end

	// Axis parameter writes; ramp limits stay with the ramp generator
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			velocity_mode <= 1'b1;
			target_velocity <= 32'sh0000_0000;
			target_position <= 32'sh0000_0000;
			target_velocity_we <= 1'b0;
			target_position_we <= 1'b0;
			move_negative <= 1'b0;
		end
		else if (ce)
		begin
			target_velocity_we <= exec && (is_rot || is_stop);
			target_position_we <= exec && is_move;
			if (exec && is_rot)
			begin
				// Value is microsteps per second, sign of code sets way
				velocity_mode <= 1'b1;
				target_velocity <= (f_instr == mci_pkg::INSTR_ROT_POS) ?
					f_value : -f_value;
			end
			else if (exec && is_stop)
			begin
				velocity_mode <= 1'b1;
				target_velocity <= 32'sh0000_0000;
			end
			else if (exec && is_move)
			begin
				velocity_mode <= 1'b0;
				target_position <= new_target;
				move_negative <= travel[31];
			end
		end
	end

	property p_reply_after_frame;
		@(posedge clk) disable iff (rst)
		(ce && frame_done && addr_ok) |=> reply_valid;
	endproperty
	a_reply_after_frame: assert property (p_reply_after_frame)
		else $error("Reply missing after frame");

	property p_bad_sum;
		@(posedge clk) disable iff (rst)
		(ce && frame_done && addr_ok && !sum_ok) |=>
			(reply_status == mci_pkg::STATUS_BAD_CHECKSUM)
			&& !target_velocity_we && !target_position_we;
	endproperty
	a_bad_sum: assert property (p_bad_sum)
		else $error("Bad checksum frame acted upon");

	property p_stop_zero;
		@(posedge clk) disable iff (rst)
		(ce && exec && is_stop) |=> velocity_mode
			&& (target_velocity == 0) && target_velocity_we;
	endproperty
	a_stop_zero: assert property (p_stop_zero)
		else $error("Stop did not zero velocity");

	property p_rot_pos;
		@(posedge clk) disable iff (rst)
		(ce && exec && f_instr == mci_pkg::INSTR_ROT_POS) |=>
			velocity_mode && (target_velocity == $past(f_value));
	endproperty
	a_rot_pos: assert property (p_rot_pos)
		else $error("Positive rotate wrong velocity");

	property p_rot_neg;
		@(posedge clk) disable iff (rst)
		(ce && exec && f_instr == mci_pkg::INSTR_ROT_NEG) |=>
			velocity_mode && (target_velocity == -$past(f_value));
	endproperty
	a_rot_neg: assert property (p_rot_neg)
		else $error("Negative rotate wrong velocity");

	property p_move_target;
		@(posedge clk) disable iff (rst)
		(ce && exec && is_move) |=> !velocity_mode && target_position_we
			&& (target_position == $past(new_target));
	endproperty
	a_move_target: assert property (p_move_target)
		else $error("Move target not written");

	property p_motor_check;
		@(posedge clk) disable iff (rst)
		(ce && frame_done && addr_ok && sum_ok && known && type_ok && !is_pt
			&& !motor_ok) |=> (reply_status == mci_pkg::STATUS_BAD_VALUE);
	endproperty
	a_motor_check: assert property (p_motor_check)
		else $error("Nonzero motor accepted");

	property p_point_range;
		@(posedge clk) disable iff (rst)
		(ce && frame_done && addr_ok && sum_ok && is_pt && !point_ok)
			|=> !target_position_we;
	endproperty
	a_point_range: assert property (p_point_range)
		else $error("Out of range point moved");

	property p_ok_status;
		@(posedge clk) disable iff (rst)
		(ce && exec) |=> (reply_status == mci_pkg::STATUS_OK);
	endproperty
	a_ok_status: assert property (p_ok_status)
		else $error("Good command not answered with OK");
endmodule : mci_motion_cmd

//--- rtl/mci_pkg.sv
// Constants shared by the motion command interpreter.
// Assumes one 10 MHz clock and a byte-wide frame input from the host link.
// Overview of operation
// - Code 1: velocity mode, positive target velocity
// - Code 2: velocity mode, negative direction velocity
// - Velocity value means step pulses per second
// - Code 3: velocity mode, target speed zero
// - Code 4 type: absolute, relative, stored point
// - Every move writes target position parameter
// - Move replies at once, never blocks
// - Positions are signed 32-bit values
// - Direction uses 32-bit wraparound difference
// - Stored point index valid up to 20
// - Stop or rotate aborts a positioning move
// - Moves use ramp parameters, not command
// - Reply status 100 for these instructions
// - Frame is nine bytes, value MSB first
package mci_pkg;
	localparam int FRAME_BYTES = 9;
	localparam logic [7:0] INSTR_ROT_POS = 8'h01;
	localparam logic [7:0] INSTR_ROT_NEG = 8'h02;
	localparam logic [7:0] INSTR_STOP = 8'h03;
	localparam logic [7:0] INSTR_MOVE = 8'h04;
	localparam logic [7:0] TYPE_ABS = 8'h00;
	localparam logic [7:0] TYPE_REL = 8'h01;
	localparam logic [7:0] TYPE_POINT = 8'h02;
	localparam logic [7:0] STATUS_OK = 8'h64;
	localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
	localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
	localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
	localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
	localparam logic [7:0] MOTOR_ONLY = 8'h00;
	localparam int POINT_COUNT = 21;
	localparam logic [31:0] POINT_MAX = 32'h0000_0014;
	localparam logic [7:0] HOST_ADDR_RESET = 8'h01;
	typedef enum logic [0:0]
	{
		MCI_MODE_VELOCITY = 1'b0,
		MCI_MODE_POSITION = 1'b1
	} mci_mode_e;
endpackage : mci_pkg

//--- verif/mci_host_model.sv
// Host side model: sends nine-byte command frames, one byte a clock.
// Assumes clk is the design clock; called only after reset is released.
`timescale 1ns/1ps
module mci_host_model
(
	input wire logic clk,
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	logic [7:0] f [9];
	initial
	begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end
	// Bytes go out MSB first; an idle line shows junk, not the old byte
	task automatic send(input logic [63:0] hv, input logic [7:0] bad);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			f[i] = hv[63 - 8 * i -: 8];
			s = s + f[i];
		end
		f[8] = s + bad;
		for (int i = 0; i < 9; i++)
		begin
			@(posedge clk) #1;
			rx_byte = f[i];
			rx_valid = 1'b1;
		end
		@(posedge clk) #1;
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask : send
endmodule : mci_host_model

//--- verif/test_motion_command_interpreter.sv
// Self-checking bench for the motion command interpreter.
// Assumes the host model drives frames; reply comes right after byte 9.
`timescale 1ns/1ps
module test_motion_command_interpreter;
	logic clk, rst, ce, rx_valid, point_we, reply_valid, velocity_mode;
	logic tv_we, tp_we, move_negative;
	logic [7:0] module_addr, rx_byte, reply_status, reply_instr;
	logic [4:0] point_idx;
	logic signed [31:0] actual_position, point_data, tv, tp;
	int n_fail = 0, total_checks = 0, cycles = 0;
	mci_host_model host (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid));
	mci_motion_cmd dut (.clk(clk), .rst(rst), .ce(ce),
		.module_addr(module_addr), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.actual_position(actual_position), .point_we(point_we),
		.point_idx(point_idx), .point_data(point_data),
		.reply_valid(reply_valid), .reply_status(reply_status),
		.reply_instr(reply_instr), .velocity_mode(velocity_mode),
		.target_velocity(tv), .target_position(tp),
		.target_velocity_we(tv_we), .target_position_we(tp_we),
		.move_negative(move_negative));
	// Clock and hang guard; the whole run needs well under 1000 cycles
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks=%0d failures=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One addressed frame, then status and echo in the pulse cycle
	task automatic cmd(input logic [31:0] h, input logic [31:0] v,
		input logic [7:0] st, input logic [7:0] bad);
		host.send({8'h01, h[23:0], v}, bad);
		chk({31'h0, reply_valid}, 32'h1);
		chk({24'h0, reply_status}, {24'h0, st});
		chk({24'h0, reply_instr}, {24'h0, h[23:16]});
	endtask : cmd
	task automatic t_rotate;
		cmd(32'h0001_0000, 32'h0000_C800, 8'h64, 8'h00);
		chk({tv_we, velocity_mode, 30'h0}, 32'hC000_0000);
		chk(tv, 32'h0000_C800);
		cmd(32'h0002_0000, 32'h0000_C800, 8'h64, 8'h00);
		chk(tv, 32'hFFFF_3800);
	endtask : t_rotate
	task automatic t_move;
		actual_position = 32'h0000_0000;
		cmd(32'h0004_0000, 32'h0001_5F90, 8'h64, 8'h00);
		chk({tp_we, velocity_mode, move_negative, 29'h0}, 32'h8000_0000);
		chk(tp, 32'h0001_5F90);
		// A move carries no speed: the velocity target must stay put
		chk(tv, 32'hFFFF_3800);
		cmd(32'h0003_0000, 32'h0000_0000, 8'h64, 8'h00);
		chk(tv, 32'h0000_0000);
		chk({31'h0, velocity_mode}, 32'h1);
		actual_position = 32'hFFFF_FFFE;
		cmd(32'h0004_0000, 32'h7FFF_FFFF, 8'h64, 8'h00);
		chk({31'h0, move_negative}, 32'h1);
		actual_position = 32'h0001_86A0;
		cmd(32'h0004_0100, 32'hFFFF_D8F0, 8'h64, 8'h00);
		chk(tp, 32'h0001_5F90);
	endtask : t_move
	task automatic t_point;
		point_we = 1'b1;
		point_idx = 5'h14;
		point_data = 32'hFFFF_FFFB;
		@(posedge clk) #1;
		point_we = 1'b0;
		actual_position = 32'h0000_0000;
		cmd(32'h0004_0207, 32'h0000_0014, 8'h64, 8'h00);
		chk(tp, 32'hFFFF_FFFB);
		chk({31'h0, move_negative}, 32'h1);
		cmd(32'h0004_0200, 32'h0000_0015, 8'h04, 8'h00);
		chk(tp, 32'hFFFF_FFFB);
	endtask : t_point
	// Each faulty frame must be answered with its error and change nothing; a frame for another address gets no reply
	task automatic t_refuse;
		cmd(32'h0004_0000, 32'h0000_0001, 8'h01, 8'h01);
		cmd(32'h0001_0001, 32'h0000_0001, 8'h04, 8'h00);
		cmd(32'h0009_0000, 32'h0000_0001, 8'h02, 8'h00);
		cmd(32'h0004_0300, 32'h0000_0001, 8'h03, 8'h00);
		host.send(64'h0204_0000_0000_0001, 8'h00);
		repeat (3)
		begin
			chk({30'h0, reply_valid, tp_we}, 32'h0);
			@(posedge clk) #1;
		end
		chk(tp, 32'hFFFF_FFFB);
	endtask : t_refuse
	// With the clock enable low no byte is taken and nothing moves;
	// the frame counter must still be aligned for the next frame
	task automatic t_freeze;
		ce = 1'b0;
		host.send(64'h0101_0000_0000_0005, 8'h00);
		chk({30'h0, reply_valid, tv_we}, 32'h0);
		chk(tv, 32'h0000_0000);
		ce = 1'b1;
		cmd(32'h0001_0000, 32'h0000_0005, 8'h64, 8'h00);
		chk(tv, 32'h0000_0005);
	endtask : t_freeze
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		module_addr = 8'h01;
		actual_position = 32'h0000_0000;
		point_we = 1'b0;
		point_idx = 5'h00;
		point_data = 32'h0000_0000;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		t_rotate();
		t_move();
		t_point();
		t_refuse();
		t_freeze();
		conclude();
	end
endmodule : test_motion_command_interpreter
